// ---- core/rtc_core.sv ----
// calendar clock core: bcd time and date, two alarms, square wave, serial target
// assumes pins arrive raw and asynchronous; control inputs come from on-chip logic
// Overview of operation
// - time and date kept as bcd counters
// - date rolls at month end, leap february
// - hours in 24-hour or 12-hour with pm
// - two alarms compared with running time
// - enabled matching alarm one pulls pin low
// - shared pin: square wave or alarm two
// - serial target up to 400 kHz bus
// - data line only pulled low or released
// - reference is 32.768 kHz oscillator clock
`timescale 1ns/10ps
module rtc_core
    import rtc_pkg::*;
(
    input  wire logic       clock_in,                 // 25 MHz core clock
    input  wire logic       rst_n_in,                 // sync reset, active low
    input  wire logic       osc_in,                   // 32.768 kHz reference pin
    output wire logic       osc_out,                  // inverted reference to crystal
    input  wire logic       scl_in,                   // serial clock pin
    input  wire logic       sda_in,                   // serial data pin level
    output wire logic       sda_out,                  // serial data drive value
    output wire logic       sda_oe_out,               // serial data pull low
    input  wire logic       hour12_mode_in,           // 1: 12-hour format
    input  wire logic [1:0] alarm_en_in,              // per-alarm output enable
    input  wire logic [1:0] alarm_clear_in,           // per-alarm flag clear pulse
    input  wire logic       sqw_select_in,            // 1: square wave on shared pin
    input  wire logic [1:0] sqw_rate_in,              // square wave rate select
    output wire logic       alarm_one_irq_n_out,      // alarm one drive value
    output wire logic       alarm_one_irq_n_oe_out,   // alarm one pull low
    output wire logic       square_wave_or_alarm_two_irq_n_out,    // shared drive value
    output wire logic       square_wave_or_alarm_two_irq_n_oe_out  // shared pull low
);
    rtc_core_s  q, d;
    logic       osc_rise, tick, min_end, hr_end, day_end, sqw, wr_stb;
    logic [1:0] match;
    logic [3:0] wr_idx, rd_idx;
    logic [7:0] wr_dat, rd_dat, hour_b;

    rtc_i2c_target #(
        .ADDR (`RTC_I2C_ADDR)
    ) u_i2c (
        .clock_in     (clock_in),
        .rst_n_in     (rst_n_in),
        .scl_in       (scl_in),
        .sda_in       (sda_in),
        .sda_out      (sda_out),
        .sda_oe_out   (sda_oe_out),
        .wr_stb_out   (wr_stb),
        .wr_index_out (wr_idx),
        .wr_data_out  (wr_dat),
        .rd_index_out (rd_idx),
        .rd_data_in   (rd_dat)
    );

    assign osc_out                               = q.osc_out;
    assign alarm_one_irq_n_out                   = 1'b0;
    assign alarm_one_irq_n_oe_out                = q.a1_oe;
    assign square_wave_or_alarm_two_irq_n_out    = 1'b0;
    assign square_wave_or_alarm_two_irq_n_oe_out = q.a2_oe;

    always_comb begin
        hour_b = rtc_hour_byte(q.hour, q.pm, hour12_mode_in);
        unique case (rd_idx)
            `RTC_IX_SEC:    rd_dat = q.sec;
            `RTC_IX_MIN:    rd_dat = q.min;
            `RTC_IX_HOUR:   rd_dat = hour_b;
            `RTC_IX_DOW:    rd_dat = q.dow;
            `RTC_IX_DATE:   rd_dat = q.date;
            `RTC_IX_MONTH:  rd_dat = q.month;
            `RTC_IX_YEAR:   rd_dat = q.year;
            `RTC_IX_A1SEC:  rd_dat = q.al_sec[0];
            `RTC_IX_A1MIN:  rd_dat = q.al_min[0];
            `RTC_IX_A1HOUR: rd_dat = q.al_hour[0];
            `RTC_IX_A2SEC:  rd_dat = q.al_sec[1];
            `RTC_IX_A2MIN:  rd_dat = q.al_min[1];
            `RTC_IX_A2HOUR: rd_dat = q.al_hour[1];
            default:        rd_dat = 8'h00;
        endcase
    end

    always_comb begin
        d         = q;
        d.osc_s1  = osc_in;
        d.osc_s2  = q.osc_s1;
        d.osc_p   = q.osc_s2;
        d.osc_out = ~q.osc_s2;
        osc_rise  = q.osc_s2 & ~q.osc_p;
        tick      = osc_rise && q.presc == `RTC_PRESC_MAX;
        min_end   = tick && q.sec == 8'h59;
        hr_end    = min_end && q.min == 8'h59;
        day_end   = hr_end && (hour12_mode_in ? (q.hour == 8'h11 && q.pm) : q.hour == 8'h23);
        if (osc_rise) begin
            d.presc = q.presc + 15'h1;
        end
        d.check = tick;
        if (tick) begin
            d.sec = min_end ? 8'h00 : rtc_bcd_inc(q.sec);
        end
        if (min_end) begin
            d.min = (q.min == 8'h59) ? 8'h00 : rtc_bcd_inc(q.min);
        end
        if (hr_end) begin
            if (hour12_mode_in) begin
                d.hour = (q.hour == 8'h12) ? 8'h01 : rtc_bcd_inc(q.hour);
                if (q.hour == 8'h11) begin
                    d.pm = ~q.pm;
                end
            end else begin
                d.hour = (q.hour == 8'h23) ? 8'h00 : rtc_bcd_inc(q.hour);
                d.pm   = 1'b0;
            end
        end
        if (day_end) begin
            d.dow = (q.dow == 8'h07) ? 8'h01 : rtc_bcd_inc(q.dow);
            if (q.date == rtc_last_date(q.month, q.year)) begin
                d.date = 8'h01;
                if (q.month == 8'h12) begin
                    d.month = 8'h01;
                    d.year  = (q.year == 8'h99) ? 8'h00 : rtc_bcd_inc(q.year);
                end else begin
                    d.month = rtc_bcd_inc(q.month);
                end
            end else begin
                d.date = rtc_bcd_inc(q.date);
            end
        end
        if (wr_stb) begin
            unique case (wr_idx)
                `RTC_IX_SEC: begin
                    d.sec   = {1'b0, wr_dat[6:0]};
                    d.presc = 15'h0;
                end
                `RTC_IX_MIN:    d.min   = {1'b0, wr_dat[6:0]};
                `RTC_IX_HOUR: begin
                    d.hour = hour12_mode_in ? {3'b000, wr_dat[4:0]} : {2'b00, wr_dat[5:0]};
                    d.pm   = hour12_mode_in & wr_dat[5];
                end
                `RTC_IX_DOW:    d.dow        = {5'h00, wr_dat[2:0]};
                `RTC_IX_DATE:   d.date       = {2'b00, wr_dat[5:0]};
                `RTC_IX_MONTH:  d.month      = {3'b000, wr_dat[4:0]};
                `RTC_IX_YEAR:   d.year       = wr_dat;
                `RTC_IX_A1SEC:  d.al_sec[0]  = wr_dat;
                `RTC_IX_A1MIN:  d.al_min[0]  = wr_dat;
                `RTC_IX_A1HOUR: d.al_hour[0] = wr_dat;
                `RTC_IX_A2SEC:  d.al_sec[1]  = wr_dat;
                `RTC_IX_A2MIN:  d.al_min[1]  = wr_dat;
                `RTC_IX_A2HOUR: d.al_hour[1] = wr_dat;
                default: ;
            endcase
        end
        // compare one cycle after the second advances; a new match beats a clear
        for (int i = 0; i < 2; i++) begin
            match[i]  = q.check && q.sec == q.al_sec[i] && q.min == q.al_min[i]
                        && hour_b == q.al_hour[i];
            d.flag[i] = match[i] | (q.flag[i] & ~alarm_clear_in[i]);
        end
        unique case (sqw_rate_in)
            `RTC_SQW_1HZ: sqw = q.presc[`RTC_TAP_1HZ];
            `RTC_SQW_4K:  sqw = q.presc[`RTC_TAP_4K];
            `RTC_SQW_8K:  sqw = q.presc[`RTC_TAP_8K];
            `RTC_SQW_32K: sqw = q.osc_s2;
        endcase
        d.a1_oe = q.flag[0] & alarm_en_in[0];
        d.a2_oe = sqw_select_in ? ~sqw : (q.flag[1] & alarm_en_in[1]);
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            q       <= '0;
            q.dow   <= `RTC_DOW_RST;
            q.date  <= `RTC_DATE_RST;
            q.month <= `RTC_MONTH_RST;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    property p_sec_digit;
        tick && !wr_stb && q.sec[3:0] == 4'h9 |=> q.sec[3:0] == 4'h0;
    endproperty
    a_sec_digit: assert property (p_sec_digit) else $error("bcd digit failed to wrap");

    property p_month_end;
        day_end && !wr_stb && q.date == rtc_last_date(q.month, q.year) |=> q.date == 8'h01;
    endproperty
    a_month_end: assert property (p_month_end) else $error("date missed month end");

    property p_leap_feb;
        day_end && !wr_stb && q.month == 8'h02 && q.date == 8'h28 && q.year == 8'h24
            |=> q.date == 8'h29 && q.month == 8'h02;
    endproperty
    a_leap_feb: assert property (p_leap_feb) else $error("leap day skipped");

    property p_pm_flip;
        hr_end && !wr_stb && hour12_mode_in && q.hour == 8'h11 |=> q.pm != $past(q.pm);
    endproperty
    a_pm_flip: assert property (p_pm_flip) else $error("pm not toggled at 11");

    property p_h12_wrap;
        hr_end && !wr_stb && hour12_mode_in && q.hour == 8'h12 |=> q.hour == 8'h01;
    endproperty
    a_h12_wrap: assert property (p_h12_wrap) else $error("12-hour wrap wrong");

    property p_alarm_set;
        match[0] |=> q.flag[0] ##1 (q.flag[0] || $past(alarm_clear_in[0]));
    endproperty
    a_alarm_set: assert property (p_alarm_set) else $error("alarm match lost");

    property p_irq_one;
        q.flag[0] && alarm_en_in[0] |=> alarm_one_irq_n_oe_out && !alarm_one_irq_n_out;
    endproperty
    a_irq_one: assert property (p_irq_one) else $error("alarm one not asserted");

    property p_sqw_fast;
        sqw_select_in && sqw_rate_in == `RTC_SQW_32K
            |=> square_wave_or_alarm_two_irq_n_oe_out == ~$past(q.osc_s2);
    endproperty
    a_sqw_fast: assert property (p_sqw_fast) else $error("square wave mismatch");

    property p_sec_hold;
        !tick && !wr_stb |=> $stable(q.sec);
    endproperty
    a_sec_hold: assert property (p_sec_hold) else $error("second moved off tick");

    c_alarm: cover property (!q.flag[0] ##1 q.flag[0]);
    c_day:   cover property (day_end);
    c_sqw:   cover property (sqw_select_in && q.a2_oe ##1 !q.a2_oe);
endmodule : rtc_core

// ---- core/rtc_defines.svh ----
// constants for the calendar clock core: indices, resets, divider taps, rates
// assumes inclusion by bare name from the package; the modules only use its macros
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH
`define RTC_I2C_ADDR    7'h68
`define RTC_IX_SEC      4'h0
`define RTC_IX_MIN      4'h1
`define RTC_IX_HOUR     4'h2
`define RTC_IX_DOW      4'h3
`define RTC_IX_DATE     4'h4
`define RTC_IX_MONTH    4'h5
`define RTC_IX_YEAR     4'h6
`define RTC_IX_A1SEC    4'h7
`define RTC_IX_A1MIN    4'h8
`define RTC_IX_A1HOUR   4'h9
`define RTC_IX_A2SEC    4'ha
`define RTC_IX_A2MIN    4'hb
`define RTC_IX_A2HOUR   4'hc
`define RTC_DATE_RST    8'h01
`define RTC_MONTH_RST   8'h01
`define RTC_DOW_RST     8'h01
`define RTC_PRESC_MAX   15'h7fff
`define RTC_SQW_1HZ     2'h0
`define RTC_SQW_4K      2'h1
`define RTC_SQW_8K      2'h2
`define RTC_SQW_32K     2'h3
`define RTC_TAP_8K      1
`define RTC_TAP_4K      2
`define RTC_TAP_1HZ     14
`endif

// ---- core/rtc_pkg.sv ----
// types and bcd helpers shared by the calendar clock core
// assumes rtc_defines.svh is on the include path
`include "rtc_defines.svh"
package rtc_pkg;
    typedef enum logic [2:0] {I_IDLE, I_ADDR, I_AACK, I_WDAT, I_WACK, I_RDAT, I_RACK} rtc_i2c_e;

    typedef struct packed {
        logic       scl_s1, scl_s2, scl_p, sda_s1, sda_s2, sda_p;
        rtc_i2c_e   st;
        logic [3:0] cnt, ptr, widx;
        logic [7:0] sh, wdat;
        logic       rw, first, wstb, oe;
    } rtc_i2c_s;

    typedef struct packed {
        logic            osc_s1, osc_s2, osc_p, osc_out;
        logic [14:0]     presc;
        logic [7:0]      sec, min, hour, dow, date, month, year;
        logic            pm, check;
        logic [1:0][7:0] al_sec, al_min, al_hour;
        logic [1:0]      flag;
        logic            a1_oe, a2_oe;
    } rtc_core_s;

    function automatic logic [7:0] rtc_bcd_inc(input logic [7:0] v);
        rtc_bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction : rtc_bcd_inc

    function automatic logic [7:0] rtc_last_date(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        case (mon)
            8'h02:                      rtc_last_date = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: rtc_last_date = 8'h30;
            default:                    rtc_last_date = 8'h31;
        endcase
    endfunction : rtc_last_date

    function automatic logic [7:0] rtc_hour_byte(input logic [7:0] hr, input logic pm,
                                                 input logic h12);
        rtc_hour_byte = h12 ? {2'b01, pm, hr[4:0]} : {2'b00, hr[5:0]};
    endfunction : rtc_hour_byte
endpackage : rtc_pkg

// ---- core/rtc_i2c_target.sv ----
// two-wire serial target: address match, index pointer, byte writes and reads
// assumes raw pin levels on scl/sda; the pull-up and wire level are outside
`timescale 1ns/10ps
module rtc_i2c_target
    import rtc_pkg::*;
#(
    parameter logic [6:0] ADDR = `RTC_I2C_ADDR
) (
    input  wire logic       clock_in,     // core clock
    input  wire logic       rst_n_in,     // sync reset, active low
    input  wire logic       scl_in,       // bus clock pin
    input  wire logic       sda_in,       // data pin level
    output wire logic       sda_out,      // data pin drive value, always low
    output wire logic       sda_oe_out,   // pull data low while high
    output wire logic       wr_stb_out,   // one-cycle write strobe
    output wire logic [3:0] wr_index_out, // write index
    output wire logic [7:0] wr_data_out,  // write byte
    output wire logic [3:0] rd_index_out, // read index
    input  wire logic [7:0] rd_data_in    // read byte for rd_index_out
);
    rtc_i2c_s q, d;
    logic     scl_rise, scl_fall, start, stop;

    assign sda_out      = 1'b0;
    assign sda_oe_out   = q.oe;
    assign wr_stb_out   = q.wstb;
    assign wr_index_out = q.widx;
    assign wr_data_out  = q.wdat;
    assign rd_index_out = q.ptr;

    always_comb begin
        d        = q;
        d.scl_s1 = scl_in;
        d.scl_s2 = q.scl_s1;
        d.scl_p  = q.scl_s2;
        d.sda_s1 = sda_in;
        d.sda_s2 = q.sda_s1;
        d.sda_p  = q.sda_s2;
        d.wstb   = 1'b0;
        scl_rise = q.scl_s2 & ~q.scl_p;
        scl_fall = ~q.scl_s2 & q.scl_p;
        start    = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
        stop     = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
        if (start) begin
            d.st  = I_ADDR;
            d.cnt = 4'h0;
            d.oe  = 1'b0;
        end else if (stop) begin
            d.st = I_IDLE;
            d.oe = 1'b0;
        end else if (scl_rise) begin
            if (q.st == I_ADDR || q.st == I_WDAT) begin
                d.sh  = {q.sh[6:0], q.sda_s2};
                d.cnt = q.cnt + 4'h1;
            end else if (q.st == I_RACK && q.sda_s2) begin
                d.st = I_IDLE;
            end
        end else if (scl_fall) begin
            unique case (q.st)
                I_IDLE, I_RACK: begin
                    if (q.st == I_RACK) begin
                        d.st  = I_RDAT;
                        d.sh  = rd_data_in;
                        d.cnt = 4'h0;
                        d.oe  = ~rd_data_in[7];
                    end
                end
                I_ADDR: begin
                    if (q.cnt == 4'h8) begin
                        d.st = (q.sh[7:1] == ADDR) ? I_AACK : I_IDLE;
                        d.oe = (q.sh[7:1] == ADDR);
                        d.rw = q.sh[0];
                    end
                end
                I_AACK: begin
                    d.cnt   = 4'h0;
                    d.first = 1'b1;
                    d.st    = q.rw ? I_RDAT : I_WDAT;
                    d.sh    = rd_data_in;
                    d.oe    = q.rw & ~rd_data_in[7];
                end
                I_WDAT: begin
                    if (q.cnt == 4'h8) begin
                        d.st    = I_WACK;
                        d.oe    = 1'b1;
                        d.first = 1'b0;
                        if (q.first) begin
                            d.ptr = q.sh[3:0];
                        end else begin
                            d.wstb = 1'b1;
                            d.widx = q.ptr;
                            d.wdat = q.sh;
                            d.ptr  = q.ptr + 4'h1;
                        end
                    end
                end
                I_WACK: begin
                    d.st  = I_WDAT;
                    d.cnt = 4'h0;
                    d.oe  = 1'b0;
                end
                I_RDAT: begin
                    d.cnt = q.cnt + 4'h1;
                    if (q.cnt == 4'h7) begin
                        d.st  = I_RACK;
                        d.oe  = 1'b0;
                        d.ptr = q.ptr + 4'h1;
                    end else begin
                        d.sh = {q.sh[6:0], 1'b0};
                        d.oe = ~q.sh[6];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            // an idle bus is high, so the detectors leave reset without a false edge
            q        <= '0;
            q.st     <= I_IDLE;
            q.scl_s1 <= 1'b1;
            q.scl_s2 <= 1'b1;
            q.scl_p  <= 1'b1;
            q.sda_s1 <= 1'b1;
            q.sda_s2 <= 1'b1;
            q.sda_p  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    property p_ack_match;
        q.st == I_ADDR && q.cnt == 4'h8 && scl_fall && !start && !stop
            && q.sh[7:1] != ADDR |=> !q.oe && q.st == I_IDLE;
    endproperty
    a_ack_match: assert property (p_ack_match) else $error("acked foreign address");

    property p_wr_pulse;
        q.wstb |=> !q.wstb ##1 !q.wstb;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");

    property p_open_drain;
        q.st == I_IDLE |-> sda_out == 1'b0 && !q.oe;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("data line driven");

    c_write: cover property (q.wstb);
endmodule : rtc_i2c_target

// ---- tb/rtc_i2c_master.sv ----
// behavioural two-wire bus master that faces the calendar clock core
// assumes the bench resolves the data wire as a pulled-up wired-and
`timescale 1ns/10ps
module rtc_i2c_master (
    input  wire logic clock_in,    // bench clock
    input  wire logic sda_in,      // resolved data wire level
    output logic      scl_out,     // bus clock, idle high
    output logic      sda_low_out  // pull data low while high
);
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    // 22 core cycles per step gives a 2640 ns bus period, under 400 kHz
    task automatic step();
        repeat (22) @(posedge clock_in);
        #1;
    endtask : step

    task automatic bit_io(input logic b, output logic r);
        sda_low_out = !b;
        step();
        scl_out = 1'b1;
        step();
        r = sda_in;
        scl_out = 1'b0;
        step();
    endtask : bit_io

    task automatic start();
        sda_low_out = 1'b0;
        step();
        scl_out = 1'b1;
        step();
        sda_low_out = 1'b1;
        step();
        scl_out = 1'b0;
        step();
    endtask : start

    task automatic stop();
        sda_low_out = 1'b1;
        step();
        scl_out = 1'b1;
        step();
        sda_low_out = 1'b0;
        step();
    endtask : stop

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : wr_byte

    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask : rd_byte
endmodule : rtc_i2c_master

// ---- tb/rtc_core_tb_top.sv ----
// self-checking bench for the calendar clock core with a bus master partner
// assumes the core top as declared; the bench drives the reference clock
`timescale 1ns/10ps
module rtc_core_tb_top;
    logic        clock_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        osc_in   = 1'b0;
    logic        hour12   = 1'b0;
    logic        sqw_sel  = 1'b0;
    logic [1:0]  al_en    = 2'h0;
    logic [1:0]  al_clr   = 2'h0;
    logic [1:0]  rate     = 2'h0;
    logic        scl, m_low, sda, sda_drv, sda_oe, a1_oe, a2_oe;
    logic        sw_q     = 1'b0;
    logic [7:0]  em[16];
    logic [7:0]  wq[14];
    logic [31:0] lf       = 32'h4170ec8b;
    realtime     osc_half = 160ns;
    int          failures = 0;
    int          n_compared = 0;
    int          edges    = 0;
    logic        osc_o;
    logic [2:0]  oq       = 3'h0;
    int          up       = 0;

    assign sda = !(sda_oe || m_low);
    always #20 clock_in = !clock_in;
    always #(osc_half) osc_in = !osc_in;

    rtc_core i_rtc_core (.clock_in(clock_in), .rst_n_in(rst_n_in), .osc_in(osc_in),
        .osc_out(osc_o), .scl_in(scl), .sda_in(sda), .sda_out(sda_drv), .sda_oe_out(sda_oe),
        .hour12_mode_in(hour12), .alarm_en_in(al_en), .alarm_clear_in(al_clr),
        .sqw_select_in(sqw_sel), .sqw_rate_in(rate), .alarm_one_irq_n_out(),
        .alarm_one_irq_n_oe_out(a1_oe), .square_wave_or_alarm_two_irq_n_out(),
        .square_wave_or_alarm_two_irq_n_oe_out(a2_oe));
    rtc_i2c_master i_rtc_i2c_master (.clock_in(clock_in), .sda_in(sda), .scl_out(scl),
        .sda_low_out(m_low));

    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp

    always @(posedge clock_in) begin
        sw_q <= a2_oe;
        if (sw_q && !a2_oe) edges <= edges + 1;
        if (sda_oe) cmp({7'h0, sda_drv}, 8'h00);
        // crystal drive is the inverted reference, three core edges late
        oq <= {oq[1:0], osc_in};
        up <= rst_n_in ? up + 1 : 0;
        if (up > 3) cmp({7'h0, osc_o}, {7'h0, !oq[2]});
    end

    task automatic tk(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : tk

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic int b2i(input logic [7:0] b);
        return b[7:4] * 10 + b[3:0];
    endfunction : b2i

    function automatic logic [7:0] i2b(input int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction : i2b

    // one seconds advance of the model, 12-hour format only
    task automatic model_tick();
        int s, m, h, d, mo, y, ld;
        s = b2i(em[0]) + 1;
        m = b2i(em[1]) + s / 60;
        h = b2i({3'h0, em[2][4:0]}) % 12 + (em[2][5] ? 12 : 0) + m / 60;
        d = b2i(em[4]) + h / 24;
        mo = b2i(em[5]);
        y = b2i(em[6]);
        ld = (mo == 2) ? ((y % 4 == 0) ? 29 : 28) :
             (mo == 4 || mo == 6 || mo == 9 || mo == 11) ? 30 : 31;
        if (h / 24 != 0) em[3] = (em[3] == 8'h07) ? 8'h01 : em[3] + 8'h01;
        if (d > ld) begin
            d = 1;
            mo++;
        end
        if (mo > 12) begin
            mo = 1;
            y = (y + 1) % 100;
        end
        h = h % 24;
        em[0] = i2b(s % 60);
        em[1] = i2b(m % 60);
        em[2] = {2'b01, h >= 12, 5'(i2b((h % 12 == 0) ? 12 : h % 12))};
        em[4] = i2b(d);
        em[5] = i2b(mo);
        em[6] = i2b(y);
    endtask : model_tick

    task automatic put(input logic [7:0] d, input logic exp);
        logic ack;
        i_rtc_i2c_master.wr_byte(d, ack);
        cmp({7'h0, ack}, {7'h0, exp});
    endtask : put

    task automatic wr(input int n);
        i_rtc_i2c_master.start();
        put(8'hd0, 1'b1);
        put(8'h00, 1'b1);
        for (int k = 0; k < n; k++) put(wq[k], 1'b1);
        i_rtc_i2c_master.stop();
    endtask : wr

    task automatic rd(input int n);
        logic [7:0] d;
        i_rtc_i2c_master.start();
        put(8'hd0, 1'b1);
        put(8'h00, 1'b1);
        i_rtc_i2c_master.start();
        put(8'hd1, 1'b1);
        for (int k = 0; k < n; k++) begin
            i_rtc_i2c_master.rd_byte(k == n - 1, d);
            cmp(d, em[k]);
        end
        i_rtc_i2c_master.stop();
    endtask : rd

    task automatic final_report();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    initial begin
        // the full run needs about 3.7 ms
        #4ms;
        failures++;
        final_report();
    end

    initial begin
        int v;
        int w;
        int div[4];
        div = '{0, 8, 4, 1};
        foreach (em[k]) em[k] = 8'h00;
        em[3] = 8'h01;
        em[4] = 8'h01;
        em[5] = 8'h01;
        tk(2);
        rst_n_in = 1'b1;
        tk(3);
        cmp({6'h0, a1_oe, a2_oe}, 8'h00);
        rd(13);
        i_rtc_i2c_master.start();
        put(8'hd2, 1'b0);
        i_rtc_i2c_master.stop();
        sqw_sel = 1'b1;
        for (int r = 0; r < 4; r++) begin
            rate = 2'(r);
            repeat (8) @(posedge osc_in);
            tk(1);
            edges = 0;
            repeat (64) @(posedge osc_in);
            tk(1);
            w = (r == 0) ? 0 : 64 / div[r];
            cmp({7'h0, edges > w + 1 || edges + 1 < w}, 8'h00);
        end
        sqw_sel = 1'b0;
        hour12 = 1'b1;
        lf = lfsr(lf);
        v = int'(lf % 32'd59) + 1;
        wq = '{8'h59, 8'h59, 8'h71, 8'h07, 8'h29, 8'h02, 8'h96, 8'h00, 8'h00, 8'h52,
               i2b(v), 8'h00, 8'h52, 8'haa};
        for (int k = 0; k < 13; k++) em[k] = wq[k];
        wr(14);
        // fast reference from here so that the next second falls inside the run
        osc_half = 40ns;
        rd(14);
        al_en = 2'h3;
        model_tick();
        for (w = 0; w < 100000 && a1_oe !== 1'b1; w++) tk(1);
        tk(2);
        cmp({6'h0, a1_oe, a2_oe}, {6'h0, 1'b1,
            em[0] == em[10] && em[1] == em[11] && em[2] == em[12]});
        rd(7);
        al_en = 2'h2;
        tk(3);
        cmp({7'h0, a1_oe}, 8'h00);
        al_en = 2'h3;
        tk(3);
        cmp({7'h0, a1_oe}, 8'h01);
        al_clr = 2'h1;
        tk(1);
        al_clr = 2'h0;
        tk(3);
        cmp({7'h0, a1_oe}, 8'h00);
        final_report();
    end
endmodule : rtc_core_tb_top
